// ---- osa_readout.sv ----
`timescale 1ns/1ps
// What this block does
// - A high output-mode select picks the differential serial mode.
// - Each pair carries two 16-bit results, read with 32 serial clock cycles single-rate or 16 double-rate.
// - Pair A shifts channel 1 MSB first, then 2, then 3 through 8 in order.
// - Pair B shifts channel 3, then 4, then 5, 6, 7, 8, 1 and 2.
// - Pair C shifts channel 5, then 6, then 7, 8, 1, 2, 3 and 4.
// - Pair D shifts channel 7, then 8, then 1, 2, 3, 4, 5 and 6.
// - Rate select low advances bits on falling edges only, high on every edge.
// - The clock output is the serial clock passed straight through; delay and skew matching are left to the pad.
// - A falling convert strobe starts conversion of the previously acquired samples.
// - Conversion is successive approximation over binary weights, giving a 16-bit code.
// - Each result is two's complement over 65536 levels of the differential span.
// - The block sustains 1.5 Msps per channel and reads out the same conversion.
// - Convert strobe high acquires the inputs; low converts and enables readout.
module osa_readout
	import osa_pkg::*;
(
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	input  wire logic                          i_convert_strobe,
	input  wire logic                          i_ser_clk,
	input  wire logic                          i_data_rate_select,
	input  wire logic                          i_out_mode_sel,
	input  wire logic [NUM_CH-1:0][AIN_W-1:0]  i_ain,
	output logic                               o_out_pair_a,
	output logic                               o_out_pair_b,
	output logic                               o_out_pair_c,
	output logic                               o_out_pair_d,
	output logic                               o_echo_clock_out,
	output logic                               o_lvds_mode
);
	localparam int conv_bound = CONV_PERIOD_CYC;

	// Trial bit test against the held input
	function automatic logic [RES_W-1:0] sar_step(
		input logic [RES_W-1:0] res,
		input logic [3:0]       bpos,
		input logic [AIN_W-1:0] smp
	);
		logic [RES_W-1:0] trial;
		trial = res | (RES_W'(1) << bpos);
		return (smp >= {trial, 2'b00}) ? trial : res;
	endfunction

	// Offset code to signed code
	function automatic logic [RES_W-1:0] to_twos(input logic [RES_W-1:0] c);
		return c ^ SIGN_FLIP;
	endfunction

	// Rotating channel order per pair
	function automatic logic pair_bit(
		input logic [NUM_CH-1:0][RES_W-1:0] b,
		input logic [1:0]                   p,
		input logic [IDX_W-1:0]             i
	);
		logic [2:0] ch;
		ch = 3'({p, 1'b0} + i[6:4]);
		return b[ch][~i[3:0]];
	endfunction

	logic                          strobe_s;
	logic                          mode_s;
	logic                          rate_s;
	logic                          busy_s;
	logic [NUM_CH-1:0][AIN_W-1:0]  ain_s;
	logic                          strobe_d_reg;
	logic                          cnv_fall;
	osa_sar_state_t                sar_state_reg;
	logic [NUM_CH-1:0][AIN_W-1:0]  sample_reg;
	logic [NUM_CH-1:0][RES_W-1:0]  res_reg;
	logic [3:0]                    bit_reg;
	logic [2:0]                    push_ch_reg;
	logic [2:0]                    load_ch_reg;
	logic [NUM_CH-1:0][RES_W-1:0]  bank_reg;
	logic                          bank_ready_reg;
	logic                          lvds_reg;
	logic                          rate_reg;
	logic                          link_clr;
	logic [IDX_W-1:0]              neg_cnt_reg;
	logic [IDX_W-1:0]              pos_cnt_reg;
	logic                          busy_n_reg;
	logic                          busy_p_reg;
	logic [IDX_W-1:0]              idx;

	osa_word_if #(.W(RES_W)) sar_q ();
	osa_word_if #(.W(RES_W)) bank_q ();

	// Pin levels into the system clock
	osa_sync #(.W(3)) u_sync_ctl (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_convert_strobe, i_out_mode_sel, i_data_rate_select}),
		.o_q   ({strobe_s, mode_s, rate_s})
	);

	osa_sync #(.W(NUM_CH*AIN_W)) u_sync_ain (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (i_ain),
		.o_q   (ain_s)
	);

	// Readout activity from the link side
	osa_sync #(.W(1)) u_sync_busy (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (busy_n_reg | busy_p_reg),
		.o_q   (busy_s)
	);

	// Strobe edge detect; resets low like the synchroniser, so no false fall
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			strobe_d_reg <= 1'b0;
		end else begin
			strobe_d_reg <= strobe_s;
		end
	end
	assign cnv_fall = strobe_d_reg && !strobe_s;

	// Mode and rate straps, rate frozen outside acquisition
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lvds_reg <= 1'b0;
			rate_reg <= 1'b0;
		end else begin
			lvds_reg <= mode_s;
			if (strobe_s) begin
				rate_reg <= rate_s;
			end
		end
	end
	assign o_lvds_mode = lvds_reg;

	// Track inputs while the strobe is high
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sample_reg <= '0;
		end else if (strobe_s && sar_state_reg == SAR_IDLE) begin
			sample_reg <= ain_s;
		end
	end

	// Converter sequence; a strobe fall mid-conversion is ignored
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sar_state_reg <= SAR_IDLE;
		end else begin
			unique case (sar_state_reg)
				SAR_IDLE: begin
					if (cnv_fall) begin
						sar_state_reg <= SAR_CONV;
					end
				end
				SAR_CONV: begin
					if (bit_reg == 4'h0) begin
						sar_state_reg <= SAR_PUSH;
					end
				end
				SAR_PUSH: begin
					if (sar_q.ready && push_ch_reg == 3'h7) begin
						sar_state_reg <= SAR_IDLE;
					end
				end
				default: begin
					sar_state_reg <= SAR_IDLE;
				end
			endcase
		end
	end

	// All eight channels resolve in parallel, MSB first
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			res_reg <= '0;
			bit_reg <= SAR_MSB;
		end else if (sar_state_reg == SAR_IDLE && cnv_fall) begin
			res_reg <= '0;
			bit_reg <= SAR_MSB;
		end else if (sar_state_reg == SAR_CONV) begin
			for (int c = 0; c < NUM_CH; c++) begin
				res_reg[c] <= sar_step(res_reg[c], bit_reg, sample_reg[c]);
			end
			bit_reg <= 4'(bit_reg - 1'b1);
		end
	end

	// Push results; a full queue stalls the converter
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			push_ch_reg <= 3'h0;
		end else if (sar_state_reg == SAR_PUSH && sar_q.ready) begin
			push_ch_reg <= 3'(push_ch_reg + 1'b1);
		end
	end
	assign sar_q.valid = (sar_state_reg == SAR_PUSH);
	assign sar_q.data  = to_twos(res_reg[push_ch_reg]);

	osa_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.up    (sar_q),
		.dn    (bank_q)
	);

	// Bank refill waits while a readout is running
	assign bank_q.ready = !busy_s;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bank_reg    <= '0;
			load_ch_reg <= 3'h0;
		end else if (bank_q.valid && bank_q.ready) begin
			bank_reg[load_ch_reg] <= bank_q.data;
			load_ch_reg           <= 3'(load_ch_reg + 1'b1);
		end
	end

	// Bank complete; the last load wins over a new strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bank_ready_reg <= 1'b0;
		end else if (bank_q.valid && bank_q.ready && load_ch_reg == 3'h7) begin
			bank_ready_reg <= 1'b1;
		end else if (cnv_fall) begin
			bank_ready_reg <= 1'b0;
		end
	end

	// Link side; counters held clear while the strobe is high
	assign link_clr = i_rst || i_convert_strobe;

	always_ff @(negedge i_ser_clk or posedge link_clr) begin
		if (link_clr) begin
			neg_cnt_reg <= '0;
			busy_n_reg  <= 1'b0;
		end else begin
			neg_cnt_reg <= IDX_W'(neg_cnt_reg + 1'b1);
			busy_n_reg  <= 1'b1;
		end
	end

	always_ff @(posedge i_ser_clk or posedge link_clr) begin
		if (link_clr) begin
			pos_cnt_reg <= '0;
			busy_p_reg  <= 1'b0;
		end else begin
			pos_cnt_reg <= IDX_W'(pos_cnt_reg + 1'b1);
			busy_p_reg  <= 1'b1;
		end
	end

	// Rising edges count only in double rate
	assign idx = IDX_W'(neg_cnt_reg + (rate_reg ? pos_cnt_reg : '0));

	// Bank is stable by protocol during readout
	assign o_out_pair_a = lvds_reg && pair_bit(bank_reg, 2'd0, idx);
	assign o_out_pair_b = lvds_reg && pair_bit(bank_reg, 2'd1, idx);
	assign o_out_pair_c = lvds_reg && pair_bit(bank_reg, 2'd2, idx);
	assign o_out_pair_d = lvds_reg && pair_bit(bank_reg, 2'd3, idx);

	// Delay and skew matching live in the pad
	assign o_echo_clock_out = i_ser_clk;

	property p_mode_sel;
		@(posedge i_clk) disable iff (i_rst)
		mode_s |=> o_lvds_mode;
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("mode select ignored");

	property p_conv_start;
		@(posedge i_clk) disable iff (i_rst)
		(sar_state_reg == SAR_IDLE && cnv_fall) |=>
			(sar_state_reg == SAR_CONV && bit_reg == SAR_MSB) ##15
			(sar_state_reg == SAR_CONV && bit_reg == 4'h0) ##1
			(sar_state_reg == SAR_PUSH);
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("conversion length wrong");

	property p_sar_msb;
		@(posedge i_clk) disable iff (i_rst)
		(sar_state_reg == SAR_CONV && bit_reg == SAR_MSB) |=>
			res_reg[0][15] == (sample_reg[0] >= {SIGN_FLIP, 2'b00});
	endproperty
	a_sar_msb: assert property (p_sar_msb) else $error("msb decision wrong");

	property p_twos;
		@(posedge i_clk) disable iff (i_rst)
		sar_q.valid |-> sar_q.data[15] == !res_reg[push_ch_reg][15];
	endproperty
	a_twos: assert property (p_twos) else $error("sign bit not inverted");

	property p_no_latency;
		@(posedge i_clk) disable iff (i_rst)
		(sar_state_reg == SAR_IDLE && cnv_fall && !busy_s) |->
			##[1:conv_bound] bank_ready_reg;
	endproperty
	a_no_latency: assert property (p_no_latency) else $error("results late");

	property p_acquire;
		@(posedge i_clk) disable iff (i_rst)
		(strobe_s && sar_state_reg == SAR_IDLE) |=> sample_reg == $past(ain_s);
	endproperty
	a_acquire: assert property (p_acquire) else $error("input not tracked");

	property p_bank_hold;
		@(posedge i_clk) disable iff (i_rst)
		busy_s |=> $stable(bank_reg);
	endproperty
	a_bank_hold: assert property (p_bank_hold) else $error("bank changed in readout");

	property p_step;
		@(negedge i_ser_clk) disable iff (link_clr)
		##1 idx == IDX_W'($past(idx) + (rate_reg ? 2'd2 : 2'd1));
	endproperty
	a_step: assert property (p_step) else $error("bit step wrong for rate");

	property p_order_ad;
		@(negedge i_ser_clk) disable iff (link_clr)
		(lvds_reg && idx == 7'h10) |->
			o_out_pair_a == bank_reg[1][15] && o_out_pair_d == bank_reg[7][15];
	endproperty
	a_order_ad: assert property (p_order_ad) else $error("pair a or d order");

	property p_order_bc;
		@(negedge i_ser_clk) disable iff (link_clr)
		(lvds_reg && idx == 7'h20) |->
			o_out_pair_b == bank_reg[4][15] && o_out_pair_c == bank_reg[6][15];
	endproperty
	a_order_bc: assert property (p_order_bc) else $error("pair b or c order");

	c_conv_done: cover property (@(posedge i_clk) $rose(bank_ready_reg));
	c_ddr_frame: cover property (@(posedge i_ser_clk) rate_reg && idx == 7'h10);
	c_sdr_frame: cover property (@(negedge i_ser_clk) !rate_reg && idx == 7'h20);
endmodule // osa_readout

// ---- osa_pkg.sv ----
package osa_pkg;
	// Converter geometry
	localparam int RES_W      = 16;
	localparam int NUM_CH     = 8;
	localparam int NUM_PAIRS  = 4;
	localparam int AIN_W      = 18;
	localparam int FIFO_DEPTH = 32;
	localparam int IDX_W      = 7;
	// Serial clock cycles per pair and frame
	localparam int SDR_EDGES  = 32;
	localparam int DDR_EDGES  = 16;
	// Throughput and clock
	localparam int CLK_HZ          = 50000000;
	localparam int CONV_RATE_SPS   = 1500000;
	localparam int CONV_PERIOD_CYC = CLK_HZ / CONV_RATE_SPS;
	// Reset values and sign mask
	localparam logic [RES_W-1:0] RES_RST   = 16'h0000;
	localparam logic [3:0]       SAR_MSB   = 4'hf;
	localparam logic [RES_W-1:0] SIGN_FLIP = 16'h8000;

	// Gray coded along idle, convert, push
	typedef enum logic [1:0] {
		SAR_IDLE = 2'b00,
		SAR_CONV = 2'b01,
		SAR_PUSH = 2'b11
	} osa_sar_state_t;
endpackage

// ---- osa_word_if.sv ----
`timescale 1ns/1ps
interface osa_word_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- osa_sync.sv ----
`timescale 1ns/1ps
module osa_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	// Two flops; only the second is visible outside
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= '0;
			o_q      <= '0;
		end else begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule // osa_sync

// ---- osa_fifo.sv ----
`timescale 1ns/1ps
module osa_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 32
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	osa_word_if.snk   up,
	osa_word_if.src   dn
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	logic          out_valid_reg;
	logic [W-1:0]  out_data_reg;
	logic          push;
	logic          pop;

	// Honest full: refuse while storage holds DEPTH words
	assign up.ready = (cnt_reg != (AW+1)'(DEPTH));
	assign push     = up.valid && up.ready;
	assign pop      = (cnt_reg != '0) && (!out_valid_reg || dn.ready);
	assign dn.valid = out_valid_reg;
	assign dn.data  = out_data_reg;

	// Storage has no reset, pointers do
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_reg] <= up.data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= AW'(wr_reg + 1'b1);
			end
			if (pop) begin
				rd_reg <= AW'(rd_reg + 1'b1);
			end
			cnt_reg <= (AW+1)'(cnt_reg + push - pop);
		end
	end

	// Registered head word
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else if (pop) begin
			out_valid_reg <= 1'b1;
			out_data_reg  <= mem[rd_reg];
		end else if (dn.ready) begin
			out_valid_reg <= 1'b0;
		end
	end

	property p_fifo_full;
		@(posedge i_clk) disable iff (i_rst)
		cnt_reg == (AW+1)'(DEPTH) |-> !up.ready;
	endproperty
	a_fifo_full: assert property (p_fifo_full) else $error("fifo accepted while full");
	c_fifo_full: cover property (@(posedge i_clk) cnt_reg == (AW+1)'(DEPTH));
endmodule // osa_fifo

// ---- osa_host_model.sv ----
`timescale 1ns/1ps
module osa_host_model (
	input  wire logic              i_go,
	input  wire logic              i_ddr,
	input  wire logic [7:0]        i_edges,
	input  wire logic [3:0]        i_pairs,
	output logic                   o_convert_strobe,
	output logic                   o_ser_clk,
	output logic [3:0][127:0]      o_cap,
	output logic                   o_done
);
	int n;

	// Idle: acquiring, serial clock parked low between frames
	initial begin
		o_convert_strobe = 1'b1;
		o_ser_clk        = 1'b0;
		o_cap            = '0;
		o_done           = 1'b0;
	end

	// One frame per go; 12 ns serial clock only inside the frame
	always begin
		wait (i_go);
		o_cap = '0;
		#200 o_convert_strobe = 1'b0;
		#800;
		n = 0;
		while (n < int'(i_edges)) begin
			#3;
			// Sample mid half-period, well clear of the launching edge
			if (i_ddr || o_ser_clk) begin
				for (int p = 0; p < 4; p++) begin
					o_cap[p][n] = i_pairs[p];
				end
			end
			#3;
			if (i_ddr || o_ser_clk) begin
				n++;
			end
			o_ser_clk = ~o_ser_clk;
		end
		#20 o_convert_strobe = 1'b1;
		o_done = 1'b1;
		wait (!i_go);
		o_done = 1'b0;
	end
endmodule // osa_host_model

// ---- osa_readout_tb_top.sv ----
`timescale 1ns/1ps
module osa_readout_tb_top
	import osa_pkg::*;
;
	logic                         clk;
	logic                         rst;
	logic                         ddr;
	logic                         mode;
	logic                         go;
	logic                         strobe;
	logic                         sclk;
	logic                         echo;
	logic                         lvds;
	logic                         done;
	logic [3:0]                   pairs;
	logic [7:0]                   edges;
	logic [3:0][127:0]            cap;
	logic [NUM_CH-1:0][AIN_W-1:0] ain;
	logic [NUM_CH-1:0][AIN_W-1:0] exp_ain;
	int                           miscompares;
	int                           checks_done;

	// 50 MHz system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	osa_readout DUT (
		.i_clk              (clk),
		.i_rst              (rst),
		.i_convert_strobe   (strobe),
		.i_ser_clk          (sclk),
		.i_data_rate_select (ddr),
		.i_out_mode_sel     (mode),
		.i_ain              (ain),
		.o_out_pair_a       (pairs[0]),
		.o_out_pair_b       (pairs[1]),
		.o_out_pair_c       (pairs[2]),
		.o_out_pair_d       (pairs[3]),
		.o_echo_clock_out   (echo),
		.o_lvds_mode        (lvds)
	);

	osa_host_model host (
		.i_go             (go),
		.i_ddr            (ddr),
		.i_edges          (edges),
		.i_pairs          (pairs),
		.o_convert_strobe (strobe),
		.o_ser_clk        (sclk),
		.o_cap            (cap),
		.o_done           (done)
	);

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
			miscompares++;
		end
	endtask

	// Echo is combinational, so it must match the serial clock 1 ns later
	always @(sclk) begin
		#1;
		chk({15'h0000, echo}, {15'h0000, sclk}, "echo clock");
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// Bounded wait; running out ends the run
	task automatic wait_lvl(ref logic sig, input logic lvl, input int lim);
		int i;
		i = 0;
		while (sig !== lvl && i < lim) begin
			@(posedge clk);
			i++;
		end
		#2;
		if (sig !== lvl) begin
			$display("unexpected at %0t: wait ran out", $time);
			miscompares++;
			complete_run();
		end
	endtask

	// Offset binary input: top 16 bits, sign bit inverted
	function automatic logic [15:0] code_of(input logic [AIN_W-1:0] a);
		return {~a[AIN_W-1], a[AIN_W-2:2]};
	endfunction

	// Optional mid-conversion input change proves the held sample is used
	task automatic run_frame(input logic rate, input logic [7:0] n, input logic swap);
		ddr = rate;
		edges = n;
		go = 1'b1;
		if (swap) begin
			wait_lvl(strobe, 1'b0, 100);
			tick(10);
			ain = ~ain;
		end
		wait_lvl(done, 1'b1, 400);
		go = 1'b0;
		wait_lvl(done, 1'b0, 10);
	endtask

	task automatic check_pairs(input int n);
		int          c;
		logic [15:0] e;
		for (int p = 0; p < NUM_PAIRS; p++) begin
			for (int k = 0; k < n; k++) begin
				c = (2 * p + k / RES_W) % NUM_CH;
				e = code_of(exp_ain[c]);
				chk({15'h0000, cap[p][k]}, {15'h0000, e[RES_W-1-(k%RES_W)]}, "bit");
			end
		end
	endtask

	task automatic set_ain(input logic [NUM_CH-1:0][AIN_W-1:0] v);
		ain = v;
		exp_ain = v;
	endtask

	task automatic t_reset();
		tick(10);
		chk({12'h000, pairs}, 16'h0000, "pairs in reset");
		chk({15'h0000, lvds}, 16'h0000, "mode in reset");
		tick(10);
		rst = 1'b0;
		wait_lvl(lvds, 1'b1, 5);
		chk({15'h0000, lvds}, 16'h0001, "mode after reset");
	endtask

	// Full rotation, single rate, with code boundaries on channels 1 to 4
	task automatic t_sdr_full();
		set_ain({18'h2aaaa, 18'h15555, 18'h00001, 18'h3fffe,
			18'h1ffff, 18'h20000, 18'h3ffff, 18'h00000});
		run_frame(1'b0, 8'h80, 1'b0);
		check_pairs(128);
	endtask

	task automatic t_ddr_full();
		set_ain({18'h0f0f3, 18'h3c3c0, 18'h12345, 18'h2edcb,
			18'h0aa55, 18'h35aa4, 18'h01230, 18'h3e001});
		run_frame(1'b1, 8'h80, 1'b0);
		check_pairs(128);
	endtask

	// Consecutive frames each read their own conversion
	task automatic t_back_to_back();
		set_ain({18'h00100, 18'h00200, 18'h00300, 18'h00400,
			18'h00500, 18'h00600, 18'h00700, 18'h00800});
		run_frame(1'b0, 8'h20, 1'b0);
		check_pairs(32);
		set_ain({18'h3f000, 18'h3e000, 18'h3d000, 18'h3c000,
			18'h3b000, 18'h3a000, 18'h39000, 18'h38000});
		run_frame(1'b1, 8'h20, 1'b0);
		check_pairs(32);
	endtask

	task automatic t_hold();
		set_ain({18'h2468a, 18'h13579, 18'h0beef, 18'h3cafe,
			18'h1f00d, 18'h2d00b, 18'h05a5a, 18'h3a5a5});
		run_frame(1'b0, 8'h20, 1'b1);
		check_pairs(32);
	endtask

	// Mode select low: no differential output
	task automatic t_mode_low();
		mode = 1'b0;
		wait_lvl(lvds, 1'b0, 5);
		chk({15'h0000, lvds}, 16'h0000, "mode low");
		run_frame(1'b0, 8'h20, 1'b0);
		for (int p = 0; p < NUM_PAIRS; p++) begin
			chk(cap[p][15:0], 16'h0000, "quiet pair");
			chk(cap[p][31:16], 16'h0000, "quiet pair");
		end
		mode = 1'b1;
		wait_lvl(lvds, 1'b1, 5);
	endtask

	// Main sequence
	initial begin
		miscompares = 0;
		checks_done = 0;
		rst = 1'b1;
		mode = 1'b1;
		ddr = 1'b0;
		go = 1'b0;
		edges = 8'h00;
		ain = '0;
		exp_ain = '0;
		t_reset();
		t_sdr_full();
		t_ddr_full();
		t_back_to_back();
		t_hold();
		t_mode_low();
		complete_run();
	end
endmodule // osa_readout_tb_top
